// ===== rtl/status_pkg.sv
// Summary of operation
// - Brake sequence reported per axis as 0 engaged..3 engaging, zero after reset.
// - Safety fault indicator reads 0 without fault, 1 while in fault.
// - Application parameter size is 0 for local parameters, 4 bytes over bus.
// - Communication parameter size is fixed two bytes, the 16-bit watchdog time.
// - Master assigns a session number 1..65535; device holds and reports it.
// - Link role code always reads constant 2, meaning slave.
// - Latest protocol fault recorded; codes 0..3 are reset, command and session faults.
// - Fault codes 4..7 are checksum, watchdog, slave address, safety data.
// - Fault codes 8..11 are comm and application parameter length and data.
// - Protocol revision in use is exposed as a 16-bit value.
// - Axis safe address is node identifier times one hundred plus axis number.
// - Application parameter checksum is exposed for the master to validate.
package status_pkg;

   // Bus geometry
   localparam int ADDR_W   = 9;
   localparam int MAX_AXES = 4;

   // Per-axis register offsets inside one axis window
   localparam logic [5:0] OFS_BRAKE    = 6'h00;
   localparam logic [5:0] OFS_FAULT    = 6'h04;
   localparam logic [5:0] OFS_APP_SIZE = 6'h08;
   localparam logic [5:0] OFS_COMM_SIZE = 6'h0C;
   localparam logic [5:0] OFS_SESSION  = 6'h10;
   localparam logic [5:0] OFS_ROLE     = 6'h14;
   localparam logic [5:0] OFS_LAST_FLT = 6'h18;
   localparam logic [5:0] OFS_REVISION = 6'h1C;
   localparam logic [5:0] OFS_SAFE_ADR = 6'h20;
   localparam logic [5:0] OFS_CHECKSUM = 6'h24;

   // Interrupt registers, above all axis windows
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 9'h100;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 9'h104;

   // Fixed values
   localparam logic [15:0] LOCAL_PARAM_BYTES = 16'h0000;
   localparam logic [15:0] APP_PARAM_BYTES   = 16'h0004;
   localparam logic [15:0] COMM_PARAM_BYTES  = 16'h0002;
   localparam logic [15:0] ROLE_SLAVE        = 16'h0002;
   localparam logic [15:0] ADDR_SCALE        = 16'h0064;

   // Brake sequence codes
   localparam logic [1:0] BRAKE_ENGAGED   = 2'h0;
   localparam logic [1:0] BRAKE_RELEASING = 2'h1;
   localparam logic [1:0] BRAKE_RELEASED  = 2'h2;
   localparam logic [1:0] BRAKE_ENGAGING  = 2'h3;

   // Protocol fault codes
   localparam logic [7:0] FLT_RESET        = 8'h00;
   localparam logic [7:0] FLT_UNEXP_CMD    = 8'h01;
   localparam logic [7:0] FLT_UNKNOWN_CMD  = 8'h02;
   localparam logic [7:0] FLT_BAD_SESSION  = 8'h03;
   localparam logic [7:0] FLT_CHECKSUM     = 8'h04;
   localparam logic [7:0] FLT_WATCHDOG     = 8'h05;
   localparam logic [7:0] FLT_SLAVE_ADDR   = 8'h06;
   localparam logic [7:0] FLT_SAFE_DATA    = 8'h07;
   localparam logic [7:0] FLT_COMM_LEN     = 8'h08;
   localparam logic [7:0] FLT_COMM_DATA    = 8'h09;
   localparam logic [7:0] FLT_APP_LEN      = 8'h0A;
   localparam logic [7:0] FLT_APP_DATA     = 8'h0B;

   // Reset values
   localparam logic [7:0]  LAST_FLT_RESET = 8'h00;
   localparam logic [15:0] SESSION_RESET  = 16'h0000;

   // Interrupt event bit positions within one axis group
   localparam int EV_SESSION = 0;
   localparam int EV_PROTO   = 1;
   localparam int EV_SAFETY  = 2;
   localparam int EV_PER_AXIS = 3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Inputs from the safety core, one per axis
   typedef struct packed {
      logic [1:0]  brake_code;
      logic        safety_fault;
      logic        app_params_over_bus;
      logic        session_valid;
      logic [15:0] session_id;
      logic        fault_valid;
      logic [7:0]  fault_code;
      logic [15:0] revision;
      logic [31:0] checksum;
   } axis_in_type;

   // Held state of one axis
   typedef struct packed {
      logic [1:0]  brake;
      logic        fault;
      logic        app_over_bus;
      logic [15:0] session;
      logic [7:0]  last_fault;
      logic [15:0] revision;
      logic [15:0] safe_addr;
      logic [31:0] checksum;
   } axis_state_type;

endpackage

// ===== rtl/safety_status_parameters.sv
`timescale 1ns/1ps
module safety_status_parameters #(
   parameter int NUM_AXES = 2
) (
   // Clock and reset
   input  wire logic                                   aclk,
   input  wire logic                                   aresetn,
   // AXI4-Lite write address and data
   input  wire logic [status_pkg::ADDR_W-1:0]          s_axi_awaddr,
   input  wire logic                                   s_axi_awvalid,
   output logic                                        s_axi_awready,
   input  wire logic [31:0]                            s_axi_wdata,
   input  wire logic [3:0]                             s_axi_wstrb,
   input  wire logic                                   s_axi_wvalid,
   output logic                                        s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                                  s_axi_bresp,
   output logic                                        s_axi_bvalid,
   input  wire logic                                   s_axi_bready,
   // AXI4-Lite read
   input  wire logic [status_pkg::ADDR_W-1:0]          s_axi_araddr,
   input  wire logic                                   s_axi_arvalid,
   output logic                                        s_axi_arready,
   output logic [31:0]                                 s_axi_rdata,
   output logic [1:0]                                  s_axi_rresp,
   output logic                                        s_axi_rvalid,
   input  wire logic                                   s_axi_rready,
   // Safety core status
   input  wire logic [6:0]                             node_safety_identifier,
   input  wire status_pkg::axis_in_type [NUM_AXES-1:0] axis_in,
   // Interrupt
   output logic                                        irq
);

   localparam int EV_W = NUM_AXES * status_pkg::EV_PER_AXIS;

   // Refuse axis counts the address map cannot hold
   if (NUM_AXES < 1 || NUM_AXES > status_pkg::MAX_AXES) begin : g_bad_axes
      $error("NUM_AXES out of range");
   end

   typedef struct packed {
      logic                                       aw_full;
      logic [status_pkg::ADDR_W-1:0]              aw_addr;
      logic                                       w_full;
      logic [31:0]                                w_data;
      logic [3:0]                                 w_strb;
      logic                                       bvalid;
      logic [1:0]                                 bresp;
      logic                                       rvalid;
      logic [1:0]                                 rresp;
      logic [31:0]                                rdata;
      status_pkg::axis_state_type [NUM_AXES-1:0]  axis;
      logic [EV_W-1:0]                            irq_status;
      logic [EV_W-1:0]                            irq_mask;
   } state_type;

   state_type state_reg;
   state_type state_next;

   // Widen byte strobes into a bit mask
   function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction

   // True where an address names a mapped register
   function automatic logic addr_mapped(input logic [status_pkg::ADDR_W-1:0] addr);
      logic ok;
      ok = 1'b0;
      if (addr == status_pkg::OFS_IRQ_STATUS || addr == status_pkg::OFS_IRQ_MASK) begin
         ok = 1'b1;
      end else if (!addr[8] && int'(addr[7:6]) < NUM_AXES) begin
         unique case (addr[5:0])
            status_pkg::OFS_BRAKE, status_pkg::OFS_FAULT, status_pkg::OFS_APP_SIZE,
            status_pkg::OFS_COMM_SIZE, status_pkg::OFS_SESSION, status_pkg::OFS_ROLE,
            status_pkg::OFS_LAST_FLT, status_pkg::OFS_REVISION,
            status_pkg::OFS_SAFE_ADR, status_pkg::OFS_CHECKSUM: begin
               ok = 1'b1;
            end
            default: begin
               ok = 1'b0;
            end
         endcase
      end
      return ok;
   endfunction

   // Read data for a mapped address; narrow fields sit in the low bits
   function automatic logic [31:0] read_word(input logic [status_pkg::ADDR_W-1:0] addr,
                                             input state_type s);
      logic [31:0]                w;
      status_pkg::axis_state_type x;
      w = '0;
      x = s.axis[0];
      for (int a = 0; a < NUM_AXES; a++) begin
         if (int'(addr[7:6]) == a) begin
            x = s.axis[a];
         end
      end
      if (addr == status_pkg::OFS_IRQ_STATUS) begin
         w[EV_W-1:0] = s.irq_status;
      end else if (addr == status_pkg::OFS_IRQ_MASK) begin
         w[EV_W-1:0] = s.irq_mask;
      end else begin
         unique case (addr[5:0])
            status_pkg::OFS_BRAKE: begin
               w[1:0] = x.brake;
            end
            status_pkg::OFS_FAULT: begin
               w[0] = x.fault;
            end
            status_pkg::OFS_APP_SIZE: begin
               w[15:0] = x.app_over_bus ? status_pkg::APP_PARAM_BYTES
                                        : status_pkg::LOCAL_PARAM_BYTES;
            end
            status_pkg::OFS_COMM_SIZE: begin
               w[15:0] = status_pkg::COMM_PARAM_BYTES;
            end
            status_pkg::OFS_SESSION: begin
               w[15:0] = x.session;
            end
            status_pkg::OFS_ROLE: begin
               w[15:0] = status_pkg::ROLE_SLAVE;
            end
            status_pkg::OFS_LAST_FLT: begin
               w[7:0] = x.last_fault;
            end
            status_pkg::OFS_REVISION: begin
               w[15:0] = x.revision;
            end
            status_pkg::OFS_SAFE_ADR: begin
               w[15:0] = x.safe_addr;
            end
            status_pkg::OFS_CHECKSUM: begin
               w = x.checksum;
            end
            default: begin
               w = '0;
            end
         endcase
      end
      return w;
   endfunction

   // Handshake outputs; one write and one read in flight at a time
   assign s_axi_awready = !state_reg.aw_full && !state_reg.bvalid;
   assign s_axi_wready  = !state_reg.w_full && !state_reg.bvalid;
   assign s_axi_arready = !state_reg.rvalid;
   assign s_axi_bvalid  = state_reg.bvalid;
   assign s_axi_bresp   = state_reg.bresp;
   assign s_axi_rvalid  = state_reg.rvalid;
   assign s_axi_rresp   = state_reg.rresp;
   assign s_axi_rdata   = state_reg.rdata;

   // Level interrupt while any unmasked sticky event is set
   assign irq = |(state_reg.irq_status & state_reg.irq_mask);

   // Next-state logic: status capture, bus slave, interrupt bookkeeping
   always_comb begin
      logic [EV_W-1:0] events;
      logic [EV_W-1:0] clear;
      logic [31:0]     wmask;
      logic [15:0]     scaled;
      events     = '0;
      clear      = '0;
      wmask      = strobe_mask(state_reg.w_strb);
      scaled     = '0;
      state_next = state_reg;

      // Status follows the safety core every cycle, session and last fault only when valid; volatile, reset on power-up
      for (int a = 0; a < NUM_AXES; a++) begin
         state_next.axis[a].brake        = axis_in[a].brake_code;
         state_next.axis[a].fault        = axis_in[a].safety_fault;
         state_next.axis[a].app_over_bus = axis_in[a].app_params_over_bus;
         state_next.axis[a].revision     = axis_in[a].revision;
         state_next.axis[a].checksum     = axis_in[a].checksum;
         scaled = 16'(node_safety_identifier * status_pkg::ADDR_SCALE);
         state_next.axis[a].safe_addr    = 16'(scaled + 16'(a + 1));
         // Zero is no legal session number, so it never overwrites a held one
         if (axis_in[a].session_valid && axis_in[a].session_id != '0) begin
            state_next.axis[a].session = axis_in[a].session_id;
            events[a*status_pkg::EV_PER_AXIS + status_pkg::EV_SESSION] = 1'b1;
         end
         if (axis_in[a].fault_valid) begin
            state_next.axis[a].last_fault = axis_in[a].fault_code;
            events[a*status_pkg::EV_PER_AXIS + status_pkg::EV_PROTO] = 1'b1;
         end
         // Rising edge of the safety fault only, so a held fault fires once
         if (axis_in[a].safety_fault && !state_reg.axis[a].fault) begin
            events[a*status_pkg::EV_PER_AXIS + status_pkg::EV_SAFETY] = 1'b1;
         end
      end

      // Address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         state_next.aw_full = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         state_next.w_full = 1'b1;
         state_next.w_data = s_axi_wdata;
         state_next.w_strb = s_axi_wstrb;
      end
      if (state_reg.bvalid && s_axi_bready) begin
         state_next.bvalid = 1'b0;
      end

      // Both halves present: perform the write; status registers drop it
      if (state_reg.aw_full && state_reg.w_full && !state_reg.bvalid) begin
         state_next.aw_full = 1'b0;
         state_next.w_full  = 1'b0;
         state_next.bvalid  = 1'b1;
         state_next.bresp   = addr_mapped(state_reg.aw_addr) ? status_pkg::RESP_OKAY
                                                             : status_pkg::RESP_DECERR;
         if (state_reg.aw_addr == status_pkg::OFS_IRQ_STATUS) begin
            clear = EV_W'(state_reg.w_data & wmask);
         end else if (state_reg.aw_addr == status_pkg::OFS_IRQ_MASK) begin
            state_next.irq_mask = EV_W'((state_reg.w_data & wmask)
                                        | ({{(32-EV_W){1'b0}}, state_reg.irq_mask} & ~wmask));
         end
         // Any other mapped address is read-only and left untouched
      end

      // A new event beats a clear written in the same cycle
      state_next.irq_status = (state_reg.irq_status & ~clear) | events;

      // Read: answer one cycle after the address is taken
      if (s_axi_arvalid && s_axi_arready) begin
         state_next.rvalid = 1'b1;
         if (addr_mapped(s_axi_araddr)) begin
            state_next.rresp = status_pkg::RESP_OKAY;
            state_next.rdata = read_word(s_axi_araddr, state_reg);
         end else begin
            state_next.rresp = status_pkg::RESP_DECERR;
            state_next.rdata = '0;
         end
      end else if (state_reg.rvalid && s_axi_rready) begin
         state_next.rvalid = 1'b0;
      end
   end

   // State register; all status clears on reset, nothing survives power loss
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
         for (int a = 0; a < NUM_AXES; a++) begin
            state_reg.axis[a].brake      <= status_pkg::BRAKE_ENGAGED;
            state_reg.axis[a].session    <= status_pkg::SESSION_RESET;
            state_reg.axis[a].last_fault <= status_pkg::LAST_FLT_RESET;
         end
      end else begin
         state_reg <= state_next;
      end
   end

endmodule // safety_status_parameters

// ===== dv/status_props.sv
`timescale 1ns/1ps
// Read-back values and responses judged at the register port
module status_props #(
   parameter int NUM_AXES = 2
) (
   // Clock and reset
   input wire logic                                   aclk,
   input wire logic                                   aresetn,
   // Bus handshakes seen
   input wire logic [8:0]                             s_axi_awaddr,
   input wire logic                                   s_axi_awvalid,
   input wire logic                                   s_axi_awready,
   input wire logic [1:0]                             s_axi_bresp,
   input wire logic                                   s_axi_bvalid,
   input wire logic [8:0]                             s_axi_araddr,
   input wire logic                                   s_axi_arvalid,
   input wire logic                                   s_axi_arready,
   input wire logic [31:0]                            s_axi_rdata,
   input wire logic [1:0]                             s_axi_rresp,
   input wire logic                                   s_axi_rvalid,
   // Core status
   input wire logic [6:0]                             node_safety_identifier,
   input wire status_pkg::axis_in_type [NUM_AXES-1:0] axis_in
);
   logic [8:0] ra;
   logic [8:0] wa;
   logic [1:0] ax;
   logic       inw;
   logic       rok;
   // Addresses of the transfers now answered
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
   end
   // Decode of the captured read address
   assign ax  = ra[7:6];
   assign inw = !ra[8] && (ax < NUM_AXES);
   assign rok = (inw && ra[5:0] <= 6'h24) || ra == 9'h100 || ra == 9'h104;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Inputs steady across the reload and the read, else the value is in flight
   property p_brake;
      $rose(s_axi_rvalid) && inw && ra[5:0] == 6'h00 && $past(axis_in, 2) == axis_in
      && $past(axis_in) == axis_in |-> s_axi_rdata == {30'h0, axis_in[ax].brake_code};
   endproperty
   a_brake: assert property (p_brake) else $error("brake state read wrong");
   property p_fault;
      $rose(s_axi_rvalid) && inw && ra[5:0] == 6'h04 && $past(axis_in, 2) == axis_in
      && $past(axis_in) == axis_in |-> s_axi_rdata == {31'h0, axis_in[ax].safety_fault};
   endproperty
   a_fault: assert property (p_fault) else $error("fault flag read wrong");
   property p_app;
      $rose(s_axi_rvalid) && inw && ra[5:0] == 6'h08 && $past(axis_in, 2) == axis_in
      |-> s_axi_rdata == (axis_in[ax].app_params_over_bus ? 32'h4 : 32'h0);
   endproperty
   a_app: assert property (p_app) else $error("app size read wrong");
   property p_comm;
      $rose(s_axi_rvalid) && inw && ra[5:0] == 6'h0C |-> s_axi_rdata == 32'h2;
   endproperty
   a_comm: assert property (p_comm) else $error("comm size read wrong");
   property p_role;
      $rose(s_axi_rvalid) && inw && ra[5:0] == 6'h14 |-> s_axi_rdata == 32'h2;
   endproperty
   a_role: assert property (p_role) else $error("role code read wrong");
   property p_addr;
      $rose(s_axi_rvalid) && inw && ra[5:0] == 6'h20
      && $past(node_safety_identifier, 2) == node_safety_identifier
      |-> s_axi_rdata == {16'h0, 16'(node_safety_identifier) * 16'h0064 + 16'(ax) + 16'h1};
   endproperty
   a_addr: assert property (p_addr) else $error("safe address read wrong");
   property p_unmapped;
      $rose(s_axi_rvalid) && !rok && ra[1:0] == 2'h0 |-> s_axi_rresp == 2'h3 && s_axi_rdata == 0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
   property p_wr_ok;
      $rose(s_axi_bvalid) && !wa[8] && wa[7:6] < NUM_AXES && wa[5:0] <= 6'h24
      && wa[1:0] == 2'h0 |-> s_axi_bresp == 2'h0;
   endproperty
   a_wr_ok: assert property (p_wr_ok) else $error("status write refused");
endmodule // status_props

bind safety_status_parameters status_props #(.NUM_AXES(NUM_AXES)) i_status_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .node_safety_identifier(node_safety_identifier),
   .axis_in(axis_in));

// ===== dv/fsoe_master_model.sv
`timescale 1ns/1ps
// Master and core side: held levels plus one-cycle event pulses
module fsoe_master_model #(
   parameter int NUM_AXES = 2
) (
   // Clock
   input wire logic                              aclk,
   // Status toward the block
   output status_pkg::axis_in_type [NUM_AXES-1:0] axis_in
);
   initial axis_in = '0;
   // Level values, held until changed
   task automatic set_axis(input int a, input logic [1:0] b, input logic f, input logic p,
                           input logic [15:0] v, input logic [31:0] c);
      @(posedge aclk);
      axis_in[a].brake_code          <= b;
      axis_in[a].safety_fault        <= f;
      axis_in[a].app_params_over_bus <= p;
      axis_in[a].revision            <= v;
      axis_in[a].checksum            <= c;
   endtask
   // Session number handed over once the connection is reached
   task automatic assign_session(input int a, input logic [15:0] id);
      @(posedge aclk);
      axis_in[a].session_valid <= 1'b1;
      axis_in[a].session_id    <= id;
      @(posedge aclk);
      axis_in[a].session_valid <= 1'b0;
      axis_in[a].session_id    <= ~id; // Stale id must not look valid
   endtask
   // Protocol fault seen by the stack
   task automatic report_fault(input int a, input logic [7:0] code);
      @(posedge aclk);
      axis_in[a].fault_valid <= 1'b1;
      axis_in[a].fault_code  <= code;
      @(posedge aclk);
      axis_in[a].fault_valid <= 1'b0;
      axis_in[a].fault_code  <= ~code;
   endtask
endmodule // fsoe_master_model

// ===== dv/safety_status_parameters_bench.sv
`timescale 1ns/1ps
module safety_status_parameters_bench;
   typedef struct packed {logic [8:0] a; logic [31:0] e;} row_type;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
   logic [8:0] awaddr = 9'h000, araddr = 9'h000, b;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [6:0] node = 7'h63;
   logic [3:0] wstrb = 4'hF;
   status_pkg::axis_in_type [1:0] axis_in;
   logic [1:0] brk [2] = '{2'h2, 2'h3};
   logic flt [2] = '{1'b1, 1'b0};
   logic [15:0] rev [2] = '{16'h0103, 16'hFFFF};
   logic [31:0] crc [2] = '{32'hA5C3_0F12, 32'h0000_0001};
   logic [15:0] ids [3] = '{16'h0001, 16'hFFFF, 16'h0000};
   row_type rows [$];
   int error_cnt = 0, checks = 0;
   // Free-running clock
   always #12.5 aclk = ~aclk;
   safety_status_parameters #(.NUM_AXES(2)) i_safety_status_parameters (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .node_safety_identifier(node), .axis_in(axis_in), .irq(irq));
   fsoe_master_model #(.NUM_AXES(2)) i_fsoe_master_model (.aclk(aclk), .axis_in(axis_in));
   task automatic finish_test();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: data %h want %h", $time, got, exp);
      end
   endtask
   task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: resp %h want %h", $time, got, exp);
      end
   endtask
   // Handshakes judged at the falling edge, so no race with the rising one
   task automatic wr(input logic [8:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb && n < 40) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      if (!tb) cmp_word(32'h0, 32'h1);
   endtask
   task automatic rd(input logic [8:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      logic ta, tv;
      n = 0;
      tv = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tv && n < 40) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tv = rvalid;
         v = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      if (!tv) cmp_word(32'h0, 32'h1);
   endtask
   task automatic rdc(input logic [8:0] a, input logic [31:0] e);
      rd(a, d, r);
      cmp_resp(r, status_pkg::RESP_OKAY);
      cmp_word(d, e);
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      #500000;
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int x = 0; x < 2; x++) begin
         i_fsoe_master_model.set_axis(x, brk[x], flt[x], flt[x], rev[x], crc[x]);
         b = {1'b0, x[1:0], 6'h00};
         rows.push_back('{b, 32'(brk[x])});
         rows.push_back('{b + 9'h004, 32'(flt[x])});
         rows.push_back('{b + 9'h008, flt[x] ? 32'h4 : 32'h0});
         rows.push_back('{b + 9'h00C, 32'h2});
         rows.push_back('{b + 9'h010, 32'h0});
         rows.push_back('{b + 9'h014, 32'h2});
         rows.push_back('{b + 9'h018, 32'h0});
         rows.push_back('{b + 9'h01C, 32'(rev[x])});
         rows.push_back('{b + 9'h020, 32'(16'(node) * 16'h0064 + 16'(x + 1))});
         rows.push_back('{b + 9'h024, crc[x]});
      end
      repeat (3) @(posedge aclk);
      foreach (rows[i]) rdc(rows[i].a, rows[i].e);
      // Every brake code, axis 0
      for (int c = 0; c < 4; c++) begin
         i_fsoe_master_model.set_axis(0, 2'(c), 1'b1, 1'b1, rev[0], crc[0]);
         rdc(9'h000, 32'(c));
      end
      // Boundary session numbers; zero must leave the last one in place
      for (int i = 0; i < 3; i++) begin
         i_fsoe_master_model.assign_session(1, ids[i]);
         rdc(9'h050, i == 0 ? 32'h1 : 32'hFFFF);
      end
      // Every fault code, with the protocol-fault interrupt unmasked
      wr(9'h104, 32'h2, r);
      rdc(9'h104, 32'h2);
      for (int c = 0; c < 12; c++) begin
         i_fsoe_master_model.report_fault(0, 8'(c));
         rdc(9'h018, 32'(c));
      end
      cmp_word({31'h0, irq}, 32'h1);
      wr(9'h100, 32'hFFFF_FFFF, r);
      cmp_word({31'h0, irq}, 32'h0);
      i_fsoe_master_model.report_fault(0, 8'h05);
      @(negedge aclk);
      cmp_word({31'h0, irq}, 32'h1);
      wr(9'h104, 32'h0, r);
      cmp_word({31'h0, irq}, 32'h0);
      // No byte lanes enabled: the mask must stay as it is
      wstrb <= 4'h0;
      wr(9'h104, 32'hFFFF_FFFF, r);
      wstrb <= 4'hF;
      rdc(9'h104, 32'h0);
      // Writes to a status word are ignored but accepted
      wr(9'h014, 32'hFFFF_FFFF, r);
      cmp_resp(r, status_pkg::RESP_OKAY);
      rdc(9'h014, 32'h2);
      // Holes in the map, and an axis window beyond the axis count
      rd(9'h028, d, r);
      cmp_resp(r, status_pkg::RESP_DECERR);
      cmp_word(d, 32'h0);
      rd(9'h0C0, d, r);
      cmp_resp(r, status_pkg::RESP_DECERR);
      wr(9'h028, 32'h1, r);
      cmp_resp(r, status_pkg::RESP_DECERR);
      // Second reset: held values are lost
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rdc(9'h050, 32'h0);
      rdc(9'h018, 32'h0);
      rdc(9'h104, 32'h0);
      finish_test();
   end
endmodule // safety_status_parameters_bench
